// ### hdl/pmc_mode_cmd.v
`timescale 1ns/1ps
`include "pmc_defs.vh"
// How it works
// - front switch in manual forces manual mode, ignoring host flags and input.
// - manual mode halts positioning and subtask program execution.
// - auto-to-manual mid-run finishes current move, then holds at program end.
// - select enable set, host request clear: mode input high manual, low auto.
// - switch auto, both flags clear: automatic mode.
// - switch auto, host manual request set: manual mode regardless.
// - priority: switch manual, then host request, then enabled mode input.
// - start in ready auto latches start; stop, pause or finish code clears.
// - stop input rising edge sets stop command and halts operation.
// - stop beats start and both jogs when active together.
// - stop behaviour chosen by a 0 to 7 setting.
// - zero-return edge latches homing; cleared by homing done or stop.
// - forward jog gives one step, then continuous after 0.1 s held.
// - reverse jog gives one step, then continuous after 0.1 s held.
module pmc_mode_cmd #(
    parameter JOG_HOLD_CYCLES = `PMC_JOG_HOLD_NS / `PMC_CLK_PERIOD_NS
) (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // operator side
    input wire switch_manual,
    input wire start_in,
    input wire stop_in,
    input wire zero_return_request,
    input wire jog_forward,
    input wire jog_reverse,
    input wire mode_input_small_unit,
    input wire mode_input_large_unit,
    // pulse generator side
    input wire move_busy,
    input wire homing_done,
    input wire at_program_end,
    input wire program_pause_code,
    input wire program_finish_code,
    // command outputs
    output reg manual_mode,
    output reg program_run,
    output reg start_cmd,
    output reg stop_cmd,
    output reg zero_return_cmd,
    output reg jog_fwd_step,
    output reg jog_rev_step,
    output reg jog_fwd_cont,
    output reg jog_rev_cont,
    output reg [`PMC_STOPSET_W-1:0] stop_behaviour_setting,
    // axi4-lite slave
    input wire [`PMC_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`PMC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    localparam NIN = 8;

    wire [NIN-1:0] raw_in;
    wire [NIN-1:0] syn;
    wire [NIN-1:0] rise;
    reg [31:0] ctrl_r;
    reg aw_held_r;
    reg w_held_r;
    reg [`PMC_ADDR_W-1:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg hold_r;
    reg clr_stop_r;
    reg mode_nxt;
    reg [1:0] warm_r;
    wire sw_man;
    wire st_in;
    wire sp_in;
    wire zr_in;
    wire jf_in;
    wire jr_in;
    wire sel_in;
    wire sel_en;
    wire host_man;
    wire wr_go;
    wire stop_edge;
    wire auto_ready;
    wire fwd_step;
    wire rev_step;
    wire fwd_cont;
    wire rev_cont;
    wire [31:0] status_w;

    assign raw_in = {mode_input_large_unit, mode_input_small_unit, jog_reverse, jog_forward,
                     zero_return_request, stop_in, start_in, switch_manual};

    // every operator input crosses two flops before use
    pmc_sync #(
        .W(NIN)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in(raw_in),
        .sync_out(syn),
        .rise_out(rise)
    );

    assign sw_man = syn[0];
    assign st_in = syn[1];
    assign sp_in = syn[2];
    assign zr_in = syn[3];
    assign jf_in = syn[4];
    assign jr_in = syn[5];
    assign sel_en = ctrl_r[`PMC_CTRL_SEL_EN];
    assign host_man = ctrl_r[`PMC_CTRL_HOST_MANUAL_MODE];
    assign sel_in = ctrl_r[`PMC_CTRL_UNIT_LARGE] ? syn[7] : syn[6];
    assign stop_edge = rise[2];

    // fixed priority mode resolution; stays manual until the synchroniser holds real pin levels,
    // otherwise its zero reset state would read as the switch in auto for two cycles
    always @* begin
        if (sw_man || !warm_r[1]) begin
            mode_nxt = 1'b1;
        end else if (host_man) begin
            mode_nxt = 1'b1;
        end else if (sel_en) begin
            mode_nxt = sel_in;
        end else begin
            mode_nxt = 1'b0;
        end
    end

    // start needs automatic, idle and no stop present
    assign auto_ready = ~manual_mode & ~hold_r & ~stop_cmd & ~move_busy;

    // jogs are manual-only and blocked while stop is held
    pmc_jog #(
        .HOLD_CYCLES(JOG_HOLD_CYCLES)
    ) u_jog_fwd (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .jog_in(jf_in),
        .jog_rise(rise[4]),
        .allow(manual_mode & ~sp_in & ~jr_in),
        .step_pulse_r(fwd_step),
        .continuous_r(fwd_cont)
    );

    pmc_jog #(
        .HOLD_CYCLES(JOG_HOLD_CYCLES)
    ) u_jog_rev (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .jog_in(jr_in),
        .jog_rise(rise[5]),
        .allow(manual_mode & ~sp_in & ~jf_in),
        .step_pulse_r(rev_step),
        .continuous_r(rev_cont)
    );

    // mode and command state
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            manual_mode <= 1'b1;
            warm_r <= 2'h0;
            program_run <= 1'b0;
            hold_r <= 1'b0;
            start_cmd <= 1'b0;
            stop_cmd <= 1'b0;
            zero_return_cmd <= 1'b0;
            jog_fwd_step <= 1'b0;
            jog_rev_step <= 1'b0;
            jog_fwd_cont <= 1'b0;
            jog_rev_cont <= 1'b0;
        end else if (clk_en) begin
            warm_r <= {warm_r[0], 1'b1};
            // going manual mid-move: finish the move, park at program end
            if (mode_nxt && !manual_mode && (start_cmd || move_busy)) begin
                hold_r <= 1'b1;
            end else if (hold_r && !move_busy && at_program_end) begin
                hold_r <= 1'b0;
            end
            if (hold_r && !move_busy && at_program_end) begin
                manual_mode <= mode_nxt;
            end else if (!hold_r && !(mode_nxt && !manual_mode && (start_cmd || move_busy))) begin
                manual_mode <= mode_nxt;
            end
            program_run <= start_cmd & ~manual_mode & ~hold_r;
            // stop edge sets, software clear loses to a new edge
            if (stop_edge) begin
                stop_cmd <= 1'b1;
            end else if (clr_stop_r) begin
                stop_cmd <= 1'b0;
            end
            if (stop_edge || sp_in || program_pause_code || program_finish_code) begin
                start_cmd <= 1'b0;
            end else if (st_in && auto_ready) begin
                start_cmd <= 1'b1;
            end
            if (stop_edge || homing_done) begin
                zero_return_cmd <= 1'b0;
            end else if (rise[3] && !stop_cmd) begin
                zero_return_cmd <= 1'b1;
            end
            jog_fwd_step <= fwd_step;
            jog_rev_step <= rev_step;
            jog_fwd_cont <= fwd_cont;
            jog_rev_cont <= rev_cont;
        end
    end

    assign status_w = {24'h00_0000, program_run, jog_rev_cont, jog_fwd_cont, hold_r,
                       zero_return_cmd, stop_cmd, start_cmd, manual_mode};

    // axi4-lite write: address and data taken in either order
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_go = aw_held_r & w_held_r;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PMC_RESP_OKAY;
            ctrl_r <= `PMC_CTRL_RESET;
            stop_behaviour_setting <= `PMC_STOPSET_RESET;
            clr_stop_r <= 1'b0;
        end else if (clk_en) begin
            clr_stop_r <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `PMC_RESP_OKAY;
                if (awaddr_r == `PMC_REG_CTRL) begin
                    if (wstrb_r[0]) begin
                        ctrl_r[7:0] <= {5'h00, wdata_r[2:0]};
                    end
                end else if (awaddr_r == `PMC_REG_STOPSET) begin
                    if (wstrb_r[0]) begin
                        stop_behaviour_setting <= wdata_r[`PMC_STOPSET_W-1:0];
                    end
                end else if (awaddr_r == `PMC_REG_EVENT) begin
                    if (wstrb_r[0]) begin
                        clr_stop_r <= wdata_r[`PMC_EV_CLR_STOP];
                    end
                end else if (awaddr_r == `PMC_REG_STATUS) begin
                    s_axi_bresp <= `PMC_RESP_OKAY; // read-only, write ignored
                end else begin
                    s_axi_bresp <= `PMC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read, one cycle after the address is taken
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PMC_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `PMC_RESP_OKAY;
                if (s_axi_araddr == `PMC_REG_CTRL) begin
                    s_axi_rdata <= {24'h00_0000, ctrl_r[7:0]};
                end else if (s_axi_araddr == `PMC_REG_STOPSET) begin
                    s_axi_rdata <= {29'h0000_0000, stop_behaviour_setting};
                end else if (s_axi_araddr == `PMC_REG_STATUS) begin
                    s_axi_rdata <= status_w;
                end else if (s_axi_araddr == `PMC_REG_EVENT) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `PMC_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // pmc_mode_cmd

// ### pkg/pmc_defs.vh
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

// axi4-lite register byte offsets
`define PMC_ADDR_W 8
`define PMC_REG_CTRL 8'h00
`define PMC_REG_STOPSET 8'h04
`define PMC_REG_STATUS 8'h08
`define PMC_REG_EVENT 8'h0c

// control register fields
`define PMC_CTRL_SEL_EN 0
`define PMC_CTRL_HOST_MANUAL_MODE 1
`define PMC_CTRL_UNIT_LARGE 2
`define PMC_CTRL_RESET 32'h0000_0000

// stop behaviour setting field
`define PMC_STOPSET_W 3
`define PMC_STOPSET_RESET 3'h0

// status register fields
`define PMC_ST_MANUAL 0
`define PMC_ST_START 1
`define PMC_ST_STOP 2
`define PMC_ST_ZRN 3
`define PMC_ST_HOLD 4
`define PMC_ST_JOG_FWD 5
`define PMC_ST_JOG_REV 6
`define PMC_ST_PROG_RUN 7

// event register write bits (one-shot)
`define PMC_EV_CLR_STOP 0

// axi responses
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2

// jog hold time before continuous pulses
`define PMC_JOG_HOLD_NS 100000000
`define PMC_CLK_PERIOD_NS 4

`endif

// ### hdl/pmc_sync.v
`timescale 1ns/1ps
// two-flop synchroniser per bit plus registered copy for edge detection
module pmc_sync #(
    parameter W = 1
) (
    // clock
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // data
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out,
    output wire [W-1:0] rise_out
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;
    reg [W-1:0] prev_r;

    // only sync_r reads meta_r, edge detect looks at sync_r and prev_r
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
            prev_r <= {W{1'b0}};
        end else if (clk_en) begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign sync_out = sync_r;
    assign rise_out = sync_r & ~prev_r;
endmodule // pmc_sync

// ### hdl/pmc_jog.v
`timescale 1ns/1ps
`include "pmc_defs.vh"
// jog: one step on turn-on, continuous after the hold time
module pmc_jog #(
    parameter HOLD_CYCLES = 25000000
) (
    // clock
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // control
    input wire jog_in,
    input wire jog_rise,
    input wire allow,
    // outputs
    output reg step_pulse_r,
    output reg continuous_r
);
    reg [31:0] hold_cnt_r;

    // count while held; blocking clears the count, which restarts from zero once allowed while still held
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hold_cnt_r <= 32'h0000_0000;
            step_pulse_r <= 1'b0;
            continuous_r <= 1'b0;
        end else if (clk_en) begin
            step_pulse_r <= allow & jog_rise;
            if (!allow || !jog_in) begin
                hold_cnt_r <= 32'h0000_0000;
                continuous_r <= 1'b0;
            end else if (hold_cnt_r >= HOLD_CYCLES - 1) begin
                continuous_r <= 1'b1;
            end else begin
                hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
            end
        end
    end
endmodule // pmc_jog

// ### tb/pmc_monitor.sv
`timescale 1ns/1ps
// checker on the mode and command ports
module pmc_monitor (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    // watched inputs
    input wire switch_manual,
    input wire stop_in,
    input wire move_busy,
    input wire at_program_end,
    input wire homing_done,
    input wire program_pause_code,
    input wire program_finish_code,
    // watched outputs
    input wire manual_mode,
    input wire program_run,
    input wire start_cmd,
    input wire stop_cmd,
    input wire zero_return_cmd,
    input wire jog_fwd_cont,
    input wire jog_rev_cont
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // six cycles covers synchroniser plus output register
    sw_manual_a: assert property ((switch_manual && at_program_end && !move_busy) [*6] |-> manual_mode)
        else $error("manual switch ignored");
    manual_halt_a: assert property (manual_mode && $past(manual_mode) |-> !program_run)
        else $error("program runs in manual");
    hold_move_a: assert property (!manual_mode && move_busy |=> !manual_mode)
        else $error("manual entered mid move");
    stop_edge_a: assert property ($rose(stop_in) |-> ##[2:6] stop_cmd)
        else $error("stop edge not latched");
    stop_start_a: assert property (stop_cmd |=> !start_cmd)
        else $error("start alive under stop");
    stop_zrn_a: assert property (stop_cmd |=> !zero_return_cmd)
        else $error("homing alive under stop");
    code_clear_a: assert property (start_cmd && (program_pause_code || program_finish_code) |-> ##[1:4] !start_cmd)
        else $error("program code left start set");
    home_done_a: assert property (zero_return_cmd && homing_done |-> ##[1:2] !zero_return_cmd)
        else $error("homing not cleared");
    jog_manual_a: assert property (!manual_mode [*3] |-> !(jog_fwd_cont || jog_rev_cont))
        else $error("jog runs in auto");
    cover property ($rose(stop_cmd));
    cover property (start_cmd && program_finish_code);
    cover property ($rose(jog_fwd_cont));
endmodule // pmc_monitor

// ### tb/pmc_partner.sv
`timescale 1ns/1ps
// stand-in for the pulse generator, one run per new command
module pmc_partner (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    // commands in
    input wire start_cmd,
    input wire zero_return_cmd,
    input wire slow,
    // status out
    output wire move_busy,
    output wire at_program_end,
    output reg homing_done
);
    reg [5:0] cnt_r;
    reg [1:0] go_r;
    wire [1:0] go = {zero_return_cmd, start_cmd};
    assign move_busy = cnt_r != 6'h00;
    assign at_program_end = cnt_r == 6'h00;
    // start on edges only, else a latched start would rerun a parked program
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_r <= 6'h00;
            go_r <= 2'h0;
            homing_done <= 1'b0;
        end else begin
            go_r <= go;
            homing_done <= (cnt_r == 6'h01) && zero_return_cmd;
            if (cnt_r != 6'h00)
                cnt_r <= cnt_r - 6'h01;
            else if (|(go & ~go_r))
                cnt_r <= slow ? 6'h28 : 6'h06;
        end
    end
endmodule // pmc_partner

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "pmc_defs.vh"
module testbench;
    logic sys_clk = 0, reset = 1, switch_manual = 1, start_in = 0, stop_in = 0, zero_return_request = 0, slow = 0;
    logic mode_input_small_unit = 0, mode_input_large_unit = 0, program_pause_code = 0, program_finish_code = 0;
    logic [1:0] jg = 2'h0;
    logic [`PMC_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    wire move_busy, homing_done, at_program_end, manual_mode, program_run, start_cmd, stop_cmd, zero_return_cmd;
    wire jog_fwd_step, jog_rev_step, jog_fwd_cont, jog_rev_cont, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [`PMC_STOPSET_W-1:0] stop_behaviour_setting;
    wire [1:0] jc = {jog_rev_cont, jog_fwd_cont};
    int checks = 0, bad_count = 0, tick = 0, i, k;
    int ns [2] = '{0, 0};
    logic [5:0] v;
    // {expect, large unit, switch, select enable, host request, mode input}
    logic [5:0] mt [8] = '{6'h2c, 6'h01, 6'h25, 6'h04, 6'h22, 6'h26, 6'h35, 6'h14};
    // operator and program-code inputs driven by pulse
    localparam int P_START = 0, P_STOP = 1, P_ZRN = 2, P_PAUSE = 3, P_FIN = 4;
    pmc_mode_cmd #(.JOG_HOLD_CYCLES(20)) pmc_mode_cmd_inst (.sys_clk, .reset, .clk_en(1'b1), .switch_manual,
        .start_in, .stop_in, .zero_return_request, .jog_forward(jg[0]), .jog_reverse(jg[1]), .mode_input_small_unit,
        .mode_input_large_unit, .move_busy, .homing_done, .at_program_end, .program_pause_code, .program_finish_code,
        .manual_mode, .program_run, .start_cmd, .stop_cmd, .zero_return_cmd, .jog_fwd_step, .jog_rev_step,
        .jog_fwd_cont, .jog_rev_cont, .stop_behaviour_setting, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    pmc_partner pmc_partner_inst (.sys_clk, .reset, .start_cmd, .zero_return_cmd, .slow, .move_busy,
        .at_program_end, .homing_done);
    initial forever #2 sys_clk = ~sys_clk;
    // negedge sampling keeps step counts clear of the launching edge
    always @(negedge sys_clk) begin
        tick = tick + 1;
        ns[0] = ns[0] + (jog_fwd_step === 1'b1);
        ns[1] = ns[1] + (jog_rev_step === 1'b1);
        if (tick == 6000) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: timeout", $time);
            finish_test;
        end
    end
    task cmp(input logic [31:0] g, input logic [31:0] e);
        checks = checks + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task drive(input int s, input logic b);
        case (s)
            P_START: start_in <= b;
            P_STOP: stop_in <= b;
            P_ZRN: zero_return_request <= b;
            P_PAUSE: program_pause_code <= b;
            default: program_finish_code <= b;
        endcase
    endtask
    task pulse(input int s);
        drive(s, 1'b1);
        cyc(4);
        drive(s, 1'b0);
        cyc(8);
    endtask
    // each channel released once its ready is seen, bready raised and never dropped
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw;
        pa = 1;
        pw = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(negedge sys_clk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge sys_clk);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        @(negedge sys_clk);
        while (s_axi_bvalid !== 1'b1) @(negedge sys_clk);
        cmp(s_axi_bresp, er);
        // bready stays up, so a following call never reassigns it in the same step
        @(posedge sys_clk);
    endtask
    task axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(negedge sys_clk);
        while (s_axi_arready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        @(negedge sys_clk);
        while (s_axi_rvalid !== 1'b1) @(negedge sys_clk);
        cmp(s_axi_rdata & m, e);
        cmp(s_axi_rresp, er);
        @(posedge sys_clk);
    endtask
    task done(input string s);
        $display("test %s finished at %0t", s, $time);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        axr(`PMC_REG_STATUS, 32'h1, 32'hff, `PMC_RESP_OKAY);
        axr(8'h10, 32'h0, 32'hffffffff, `PMC_RESP_SLVERR);
        axw(8'h10, 32'h0, `PMC_RESP_SLVERR);
        done("reset");
        // the unselected mode input gets the inverse, so a wrong pick shows
        for (i = 0; i < 8; i++) begin
            v = mt[i];
            axw(`PMC_REG_CTRL, {29'h0, v[4], v[1], v[2]}, `PMC_RESP_OKAY);
            switch_manual <= v[3];
            mode_input_small_unit <= v[4] ^ v[0];
            mode_input_large_unit <= !v[4] ^ v[0];
            cyc(8);
            cmp(manual_mode, v[5]);
        end
        done("mode");
        axw(`PMC_REG_CTRL, 32'h0, `PMC_RESP_OKAY);
        pulse(P_START);
        cmp(start_cmd, 1);
        cmp(program_run, 1);
        pulse(P_FIN);
        cmp(start_cmd, 0);
        pulse(P_START);
        pulse(P_PAUSE);
        cmp(start_cmd, 0);
        start_in <= 1'b1;
        stop_in <= 1'b1;
        cyc(12);
        axr(`PMC_REG_STATUS, 32'h4, 32'hf, `PMC_RESP_OKAY);
        start_in <= 1'b0;
        stop_in <= 1'b0;
        cyc(4);
        axw(`PMC_REG_EVENT, 32'h1, `PMC_RESP_OKAY);
        cyc(4);
        cmp(stop_cmd, 0);
        done("start stop");
        slow <= 1'b1;
        pulse(P_START);
        switch_manual <= 1'b1;
        cyc(10);
        axr(`PMC_REG_STATUS, 32'h10, 32'h11, `PMC_RESP_OKAY);
        cyc(40);
        cmp(manual_mode, 1);
        cmp(program_run, 0);
        done("hold");
        pulse(P_FIN);
        pulse(P_ZRN);
        cmp(zero_return_cmd, 1);
        cyc(40);
        cmp(zero_return_cmd, 0);
        pulse(P_ZRN);
        pulse(P_STOP);
        cmp(stop_cmd, 1);
        cmp(zero_return_cmd, 0);
        axw(`PMC_REG_EVENT, 32'h1, `PMC_RESP_OKAY);
        done("zero return");
        for (i = 0; i < 2; i++) begin
            k = ns[i];
            jg[i] <= 1'b1;
            cyc(10);
            cmp(ns[i] - k, 1);
            cmp(jc[i], 0);
            cyc(30);
            cmp(jc[i], 1);
            stop_in <= 1'b1;
            cyc(8);
            cmp(jc[i], 0);
            stop_in <= 1'b0;
            jg[i] <= 1'b0;
            cyc(8);
            axw(`PMC_REG_EVENT, 32'h1, `PMC_RESP_OKAY);
        end
        done("jog");
        // still in manual while settings change
        for (i = 0; i < 8; i++) begin
            axw(`PMC_REG_STOPSET, i, `PMC_RESP_OKAY);
            axr(`PMC_REG_STOPSET, i, 32'h7, `PMC_RESP_OKAY);
            cmp(stop_behaviour_setting, i);
        end
        done("setting");
        finish_test;
    end
endmodule // testbench
bind pmc_mode_cmd pmc_monitor pmc_monitor_inst (.sys_clk, .reset, .switch_manual, .stop_in, .move_busy,
    .at_program_end, .homing_done, .program_pause_code, .program_finish_code, .manual_mode, .program_run,
    .start_cmd, .stop_cmd, .zero_return_cmd, .jog_fwd_cont, .jog_rev_cont);
